// file: rtl/mpf_defines.svh
// Constants for the mode pin function selector.
// Assumes inclusion by bare name from the rtl folder.
`ifndef MPF_DEFINES_SVH
`define MPF_DEFINES_SVH
`define MPF_ADDR_W        24
`define MPF_NORMAL_AW     16
`define MPF_ONEMEG_AW     20
`define MPF_ADV_AW        24
`define MPF_MASK_NORMAL   24'h00FFFF
`define MPF_MASK_ONEMEG   24'h0FFFFF
`define MPF_MASK_ADV      24'hFFFFFF
`define MPF_MODE_RESET    3'h7
`define MPF_MODE_1        3'h1
`define MPF_MODE_2        3'h2
`define MPF_MODE_3        3'h3
`define MPF_MODE_4        3'h4
`define MPF_MODE_5        3'h5
`endif

// file: rtl/mpf_pkg.sv
// Types for the mode pin function selector.
// Assumes nothing beyond the defines header.
package mpf_pkg;
  typedef enum logic [2:0] {
    MPF_SAMPLE = 3'h0,
    MPF_HOLD   = 3'h1
  } mpf_state_t;
  typedef logic [2:0] mpf_mode_t;
endpackage

// file: rtl/mpf_sel_if.sv
// Carrier between the mode latch and the pin selector.
// Assumes one clock domain.
`timescale 1ns/1ps
interface mpf_sel_if;
  logic [2:0] heldMode;
  logic       modeValid;
  modport latch (output heldMode, output modeValid);
  modport user  (input heldMode, input modeValid);
endinterface

// file: rtl/mpf_mode_latch.sv
// Samples the mode straps on the first edge after reset release and holds them.
// Assumes straps are stable while reset is applied.
`timescale 1ns/1ps
`include "mpf_defines.svh"
module mpf_mode_latch
  import mpf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Straps
  input wire logic modeSelectBit0,
  input wire logic modeSelectBit1,
  input wire logic modeSelectBit2,
  // Held mode
  mpf_sel_if.latch sel
);
  mpf_state_t state_q;
  mpf_mode_t  mode_q;

  // Strap caught on the first edge after release, never in reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= MPF_SAMPLE;
    end else begin
      unique case (state_q)
        MPF_SAMPLE: begin
          state_q <= MPF_HOLD;
        end
        MPF_HOLD: begin
          state_q <= MPF_HOLD;
        end
        // Unused codes fall to hold, never a second strap sample
        default: begin
          state_q <= MPF_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= `MPF_MODE_RESET;
    end else if (state_q == MPF_SAMPLE) begin
      mode_q <= {modeSelectBit2, modeSelectBit1, modeSelectBit0};
    end
  end

  assign sel.heldMode  = mode_q;
  assign sel.modeValid = (state_q == MPF_HOLD);
endmodule // mpf_mode_latch

// file: rtl/mpf_pin_select.sv
// Pin function selector driven by the held operating mode.
// Assumes port-control inputs are synchronous to clk.
// Notes on behaviour
// - Modes 1, 3, 5 give the lower data byte pins port function after reset.
// - Modes 2 and 4 give the lower data byte pins data bus function after reset.
// - Normal CPU mode limits addresses to 64 kilobytes outside the one-megabyte modes.
// - Advanced CPU mode allows up to 16 megabytes outside the one-megabyte modes.
// - One-megabyte modes use 20-bit addresses, top four bits ignored.
// - Address line 20 is dedicated in modes 3, 4, shared in 5, undriven otherwise.
// - Clock output is dedicated in modes 1 to 4, shared with port six bit 7 in 0 and 5 to 7.
`timescale 1ns/1ps
`include "mpf_defines.svh"
module mpf_pin_select
  import mpf_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // Mode straps
  input  wire logic                    modeSelectBit0,
  input  wire logic                    modeSelectBit1,
  input  wire logic                    modeSelectBit2,
  // Software controls
  input  wire logic                    cpuAdvanced,
  input  wire logic                    lowByteBusWr,
  input  wire logic                    lowByteBusSet,
  input  wire logic                    clkPinPortSel,
  input  wire logic                    addr20PortSel,
  // Effective address
  input  wire logic [`MPF_ADDR_W-1:0] effAddr,
  // Pad selects
  output logic [2:0]                   heldModeOut,
  output logic                         modeReady,
  output logic                         portFourLinesAsBus,
  output logic                         strobesAsBus,
  output logic                         portSixLinesAsStrobes,
  output logic                         clockOutDedicated,
  output logic                         clockOutEnable,
  output logic                         addressLineTwentyEnable,
  output logic [`MPF_ADDR_W-1:0]      pinAddr
);
  mpf_sel_if sel ();

  // Straps are caught once per reset inside the latch
  mpf_mode_latch uLatch (
    .clk            (clk),
    .rst_b          (rst_b),
    .modeSelectBit0 (modeSelectBit0),
    .modeSelectBit1 (modeSelectBit1),
    .modeSelectBit2 (modeSelectBit2),
    .sel            (sel)
  );

  // Mode decodes shared by several concerns
  function automatic logic is_one_meg(input logic [2:0] m);
    is_one_meg = (m == `MPF_MODE_1) || (m == `MPF_MODE_2);
  endfunction

  function automatic logic is_ext(input logic [2:0] m);
    is_ext = (m >= `MPF_MODE_1) && (m <= `MPF_MODE_5);
  endfunction

  function automatic logic is_low_bus_default(input logic [2:0] m);
    is_low_bus_default = (m == `MPF_MODE_2) || (m == `MPF_MODE_4);
  endfunction

  function automatic logic is_clk_dedicated(input logic [2:0] m);
    is_clk_dedicated = (m >= `MPF_MODE_1) && (m <= `MPF_MODE_4);
  endfunction

  function automatic logic is_a20_dedicated(input logic [2:0] m);
    is_a20_dedicated = (m == `MPF_MODE_3) || (m == `MPF_MODE_4);
  endfunction

  function automatic logic is_a20_shared(input logic [2:0] m);
    is_a20_shared = (m == `MPF_MODE_5);
  endfunction

  logic                   modeValidDly_q;
  logic [2:0]             heldMode_q;
  logic                   lowBus_q;
  logic [`MPF_ADDR_W-1:0] addrMask;
  logic [`MPF_ADDR_W-1:0] pinAddr_d;
  logic                   portFourLinesAsBus_d;
  logic                   strobesAsBus_d;
  logic                   portSixLinesAsStrobes_d;
  logic                   clockOutDedicated_d;
  logic                   clockOutEnable_d;
  logic                   addressLineTwentyEnable_d;

  // Delayed valid marks the one edge that loads the reset default
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modeValidDly_q <= 1'b0;
    end else begin
      modeValidDly_q <= sel.modeValid;
    end
  end

  // Mode copy stays frozen until the next reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      heldMode_q <= `MPF_MODE_RESET;
    end else begin
      heldMode_q <= sel.heldMode;
    end
  end

  // Reset choice set once per reset, software may flip it later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowBus_q <= 1'b0;
    end else if (sel.modeValid && !modeValidDly_q) begin
      lowBus_q <= is_low_bus_default(sel.heldMode);
    end else if (lowByteBusWr && is_ext(heldMode_q)) begin
      lowBus_q <= lowByteBusSet;
    end
  end

  // Width limit: upper lines read zero, never stale bits
  always_comb begin
    if (is_one_meg(heldMode_q)) begin
      addrMask = `MPF_MASK_ONEMEG;
    end else if (cpuAdvanced) begin
      addrMask = `MPF_MASK_ADV;
    end else begin
      addrMask = `MPF_MASK_NORMAL;
    end
  end

  // Per-bit gate keeps each pad bit independent of the others
  for (genvar b = 0; b < `MPF_ADDR_W; b++) begin : gAddrBit
    assign pinAddr_d[b] = effAddr[b] & addrMask[b];
  end

  // Pad select next values; mode 0 falls to the single-chip side
  always_comb begin
    portFourLinesAsBus_d      = lowBus_q && is_ext(heldMode_q);
    strobesAsBus_d            = is_ext(heldMode_q);
    portSixLinesAsStrobes_d   = !is_ext(heldMode_q);
    clockOutDedicated_d       = is_clk_dedicated(heldMode_q);
    // Shared clock pin drives the clock unless taken as port bit
    clockOutEnable_d          = is_clk_dedicated(heldMode_q) || !clkPinPortSel;
    addressLineTwentyEnable_d = is_a20_dedicated(heldMode_q)
                                || (is_a20_shared(heldMode_q) && !addr20PortSel);
  end

  // Mode word shown to the pad ring
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      heldModeOut <= `MPF_MODE_RESET;
    end else begin
      heldModeOut <= heldMode_q;
    end
  end

  // Ready lags the latch by two edges, so every select has settled first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modeReady <= 1'b0;
    end else begin
      modeReady <= modeValidDly_q;
    end
  end

  // Lower data byte goes to the bus only in external modes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portFourLinesAsBus <= 1'b0;
    end else begin
      portFourLinesAsBus <= portFourLinesAsBus_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobesAsBus <= 1'b0;
    end else begin
      strobesAsBus <= strobesAsBus_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portSixLinesAsStrobes <= 1'b0;
    end else begin
      portSixLinesAsStrobes <= portSixLinesAsStrobes_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clockOutDedicated <= 1'b0;
    end else begin
      clockOutDedicated <= clockOutDedicated_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clockOutEnable <= 1'b0;
    end else begin
      clockOutEnable <= clockOutEnable_d;
    end
  end

  // Shared pin in mode 5 stays with the port when software asks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addressLineTwentyEnable <= 1'b0;
    end else begin
      addressLineTwentyEnable <= addressLineTwentyEnable_d;
    end
  end

  // One cycle of latency traded for a flop-driven address pad
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinAddr <= '0;
    end else begin
      pinAddr <= pinAddr_d;
    end
  end
endmodule // mpf_pin_select

// file: test/mpf_ext_mem.sv
// Far-side bus device model.
// Assumes pinAddr settles before each rising edge.
`timescale 1ns/1ps
module mpf_ext_mem (
  // Clock
  input  wire logic        clk,
  // Bus pins
  input  wire logic        busOn,
  input  wire logic [23:0] addrIn,
  // Observation
  output logic      [23:0] seenAddr
);
  // Only listens while strobes own the pins, keeps the last address otherwise
  always @(posedge clk) begin
    if (busOn) seenAddr <= addrIn;
  end
endmodule // mpf_ext_mem

// file: test/mpf_pin_select_checker.sv
// Port checker for the pin selector.
// Assumes binding onto mpf_pin_select.
`timescale 1ns/1ps
`include "mpf_defines.svh"
module mpf_pin_select_checker (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_b,
  // Software controls
  input wire logic                   cpuAdvanced,
  input wire logic                   lowByteBusWr,
  input wire logic                   lowByteBusSet,
  input wire logic                   clkPinPortSel,
  input wire logic                   addr20PortSel,
  // Pad selects
  input wire logic                   modeReady,
  input wire logic                   portFourLinesAsBus,
  input wire logic                   strobesAsBus,
  input wire logic                   portSixLinesAsStrobes,
  input wire logic                   clockOutDedicated,
  input wire logic                   clockOutEnable,
  input wire logic                   addressLineTwentyEnable,
  input wire logic [2:0]             heldModeOut,
  // Addresses
  input wire logic [`MPF_ADDR_W-1:0] effAddr,
  input wire logic [`MPF_ADDR_W-1:0] pinAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic oneMeg, mid;
  assign oneMeg = heldModeOut inside {3'h1, 3'h2};
  assign mid = heldModeOut inside {[3'h3:3'h5]};
  property p_portDef; $rose(modeReady) && heldModeOut[0] |-> !portFourLinesAsBus; endproperty
  a_portDef: assert property (p_portDef) else $error("portDef");
  property p_busDef; $rose(modeReady) && heldModeOut inside {3'h2, 3'h4} |-> portFourLinesAsBus;
  endproperty
  a_busDef: assert property (p_busDef) else $error("busDef");
  property p_wr; modeReady && lowByteBusWr && (oneMeg || mid)
    |-> ##2 portFourLinesAsBus == $past(lowByteBusSet, 2); endproperty
  a_wr: assert property (p_wr) else $error("wr");
  property p_a16; modeReady && mid && !cpuAdvanced
    |=> pinAddr == ($past(effAddr) & `MPF_MASK_NORMAL); endproperty
  a_a16: assert property (p_a16) else $error("a16");
  property p_a24; modeReady && mid && cpuAdvanced |=> pinAddr == $past(effAddr); endproperty
  a_a24: assert property (p_a24) else $error("a24");
  property p_a20; modeReady && oneMeg |=> pinAddr == ($past(effAddr) & `MPF_MASK_ONEMEG);
  endproperty
  a_a20: assert property (p_a20) else $error("a20");
  property p_ln20; modeReady && heldModeOut != 3'h5
    |-> addressLineTwentyEnable == (heldModeOut inside {3'h3, 3'h4}); endproperty
  a_ln20: assert property (p_ln20) else $error("ln20");
  property p_ln20s; modeReady && heldModeOut == 3'h5
    |=> addressLineTwentyEnable == !$past(addr20PortSel); endproperty
  a_ln20s: assert property (p_ln20s) else $error("ln20s");
  property p_strb; modeReady |-> strobesAsBus == (oneMeg || mid)
    && portSixLinesAsStrobes != strobesAsBus; endproperty
  a_strb: assert property (p_strb) else $error("strb");
  property p_clk; modeReady |-> clockOutDedicated == (heldModeOut inside {[3'h1:3'h4]});
  endproperty
  a_clk: assert property (p_clk) else $error("clk");
  property p_clkEn; modeReady
    |=> clockOutEnable == ((heldModeOut inside {[3'h1:3'h4]}) || !$past(clkPinPortSel));
  endproperty
  a_clkEn: assert property (p_clkEn) else $error("clkEn");
  property p_hold; modeReady |=> modeReady && $stable(heldModeOut); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  c_wr: cover property (modeReady && lowByteBusWr);
  c_adv: cover property (modeReady && mid && cpuAdvanced);
  c_rdy: cover property ($rose(modeReady));
  c_a20s: cover property (modeReady && heldModeOut == 3'h5 && !addr20PortSel);
endmodule // mpf_pin_select_checker
bind mpf_pin_select mpf_pin_select_checker i_mpf_pin_select_checker (
  .clk                     (clk),
  .rst_b                   (rst_b),
  .cpuAdvanced             (cpuAdvanced),
  .lowByteBusWr            (lowByteBusWr),
  .lowByteBusSet           (lowByteBusSet),
  .clkPinPortSel           (clkPinPortSel),
  .addr20PortSel           (addr20PortSel),
  .modeReady               (modeReady),
  .portFourLinesAsBus      (portFourLinesAsBus),
  .strobesAsBus            (strobesAsBus),
  .portSixLinesAsStrobes   (portSixLinesAsStrobes),
  .clockOutDedicated       (clockOutDedicated),
  .clockOutEnable          (clockOutEnable),
  .addressLineTwentyEnable (addressLineTwentyEnable),
  .heldModeOut             (heldModeOut),
  .effAddr                 (effAddr),
  .pinAddr                 (pinAddr)
);

// file: test/mpf_pin_select_test.sv
// Self-checking bench for the pin selector.
// Assumes the rtl folder is on the include path.
`timescale 1ns/1ps
`include "mpf_defines.svh"
module mpf_pin_select_test;
  logic clk = 0, rst_b = 0, cpuAdvanced = 0, lowByteBusWr = 0, lowByteBusSet = 0;
  logic clkPinPortSel = 0, addr20PortSel = 0, modeReady, portFourLinesAsBus, strobesAsBus;
  logic portSixLinesAsStrobes, clockOutDedicated, clockOutEnable, addressLineTwentyEnable;
  logic [2:0]  md = 3'h1, heldModeOut;
  logic [23:0] effAddr = 24'h0, pinAddr, seen;
  logic [23:0] q[$];
  logic [23:0] mask;
  int failures = 0, samples_checked = 0, seed = 32'h811f8740;
  always #25 clk = ~clk;
  mpf_pin_select i_mpf_pin_select (
    .clk                     (clk),
    .rst_b                   (rst_b),
    .modeSelectBit0          (md[0]),
    .modeSelectBit1          (md[1]),
    .modeSelectBit2          (md[2]),
    .cpuAdvanced             (cpuAdvanced),
    .lowByteBusWr            (lowByteBusWr),
    .lowByteBusSet           (lowByteBusSet),
    .clkPinPortSel           (clkPinPortSel),
    .addr20PortSel           (addr20PortSel),
    .effAddr                 (effAddr),
    .heldModeOut             (heldModeOut),
    .modeReady               (modeReady),
    .portFourLinesAsBus      (portFourLinesAsBus),
    .strobesAsBus            (strobesAsBus),
    .portSixLinesAsStrobes   (portSixLinesAsStrobes),
    .clockOutDedicated       (clockOutDedicated),
    .clockOutEnable          (clockOutEnable),
    .addressLineTwentyEnable (addressLineTwentyEnable),
    .pinAddr                 (pinAddr)
  );
  mpf_ext_mem i_mpf_ext_mem (.clk(clk), .busOn(strobesAsBus), .addrIn(pinAddr),
    .seenAddr(seen));
  task chk(string n, logic [23:0] e, logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task print_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Oldest address note against the settled output
  always @(posedge clk) begin
    #1;
    if (q.size() > 0) chk("pinAddr", q.pop_front(), pinAddr);
  end
  initial begin
    for (int m = 0; m < 8; m++) begin
      md = m[2:0];
      rst_b = 0;
      // Odd modes run advanced, so modes 3 to 5 meet both widths
      cpuAdvanced = m[0];
      {addr20PortSel, clkPinPortSel} = 2'($random(seed));
      repeat (10) @(negedge clk);
      rst_b = 1;
      for (int i = 0; i < 8 && modeReady !== 1'b1; i++) @(negedge clk);
      if (modeReady !== 1'b1) begin
        failures++;
        print_verdict();
      end
      chk("lowBus", m == 2 || m == 4, portFourLinesAsBus);
      chk("strobes", m inside {[1:5]}, strobesAsBus);
      chk("port6", !(m inside {[1:5]}), portSixLinesAsStrobes);
      chk("clkDed", m inside {[1:4]}, clockOutDedicated);
      chk("clkEn", m inside {[1:4]} || !clkPinPortSel, clockOutEnable);
      chk("a20", m inside {3, 4} || (m == 5 && !addr20PortSel),
          addressLineTwentyEnable);
      mask = (m == 1 || m == 2) ? `MPF_MASK_ONEMEG
             : (cpuAdvanced ? `MPF_MASK_ADV : `MPF_MASK_NORMAL);
      effAddr = 24'hFFFFFF;
      repeat (20) begin
        q.push_back(effAddr & mask);
        @(negedge clk);
        effAddr = 24'($random(seed));
      end
      md = ~md;
      repeat (2) @(negedge clk);
      chk("held", 24'(m), heldModeOut);
      if (m inside {[1:5]}) chk("seen", effAddr & mask, seen);
      lowByteBusSet = !(m == 2 || m == 4);
      lowByteBusWr = 1;
      @(negedge clk);
      lowByteBusWr = 0;
      repeat (2) @(negedge clk);
      chk("lowBusWr", m inside {[1:5]} && lowByteBusSet, portFourLinesAsBus);
      $display("mode %0d done", m);
    end
    print_verdict();
  end
endmodule // mpf_pin_select_test
